/* rtl/pdc_params.svh */
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// Register offsets reached through the address register.
`define PDC_OFS_READ_MASK    8'h04
`define PDC_OFS_BLINK_MASK   8'h05
`define PDC_OFS_CONTROL      8'h06
`define PDC_OFS_READBACK     8'h07

// Command select line codes.
`define PDC_SEL_ADDRESS      2'h0
`define PDC_SEL_CONTROL      2'h2

// Control register field positions.
`define PDC_CTL_MUX5         7
`define PDC_CTL_RAM_EN       6
`define PDC_CTL_RATE_HI      5
`define PDC_CTL_RATE_LO      4
`define PDC_CTL_OV1_BLINK    3
`define PDC_CTL_OV0_BLINK    2
`define PDC_CTL_OV1_SHOW     1
`define PDC_CTL_OV0_SHOW     0

// Readback register field positions.
`define PDC_RB_LOW_NIBBLE    3
`define PDC_RB_BLUE          2
`define PDC_RB_GREEN         1
`define PDC_RB_RED           0

// Reset values.
`define PDC_CONTROL_RESET    8'h43
`define PDC_READ_MASK_RESET  8'hff
`define PDC_BLINK_MASK_RESET 8'h00
`define PDC_READBACK_RESET   4'h0

// Blink timing in frames at the nominal 60 Hz refresh.
`define PDC_FRAMES_0512MS    7'h20
`define PDC_FRAMES_1024MS    7'h40
`define PDC_FRAMES_2048MS    8'h80
`define PDC_FRAMES_1024_ON75 7'h30
`endif

/* rtl/pdc_pkg.sv */
package pdc_pkg;
  // One lookup request handed to the palette stage.
  typedef struct packed {
    logic       use_palette;
    logic [1:0] overlay;
    logic [7:0] index;
  } pdc_lookup_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pdc_rgb_t;

  typedef logic [4:0][7:0] pdc_pixels_t;
  typedef logic [4:0][1:0] pdc_overlays_t;
  typedef pdc_lookup_t [4:0] pdc_lookups_t;

  // Host access sequencer, one-hot.
  typedef enum logic [2:0] {
    PDC_IDLE  = 3'b001,
    PDC_WRITE = 3'b010,
    PDC_READ  = 3'b100
  } pdc_state_t;
endpackage

/* rtl/pdc_blink.sv */
`timescale 1ns/100ps
`include "pdc_params.svh"
module pdc_blink (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_frame,
  input  wire logic [1:0] i_rate,
  output logic            o_blink_on
);
  import pdc_pkg::*;

  logic [7:0] count_q;
  logic [7:0] period;
  logic [7:0]  on_len;
  logic [15:0] rate_pair;

  // Frame counts for each rate code; 00 is the only uneven duty.
  function automatic logic [15:0] rate_frames(input logic [1:0] rate);
    case (rate)
      2'h0:    rate_frames = {1'b0, `PDC_FRAMES_1024MS, 1'b0, `PDC_FRAMES_1024_ON75};
      2'h1:    rate_frames = {1'b0, `PDC_FRAMES_0512MS, 1'b0, 7'(`PDC_FRAMES_0512MS >> 1)};
      2'h2:    rate_frames = {1'b0, `PDC_FRAMES_1024MS, 1'b0, 7'(`PDC_FRAMES_1024MS >> 1)};
      default: rate_frames = {`PDC_FRAMES_2048MS, 1'b0, `PDC_FRAMES_1024MS};
    endcase
  endfunction

  // The function result is held in a net first, since a call cannot be part-selected.
  assign rate_pair = rate_frames(i_rate);
  assign period    = rate_pair[15:8];
  assign on_len    = rate_pair[7:0];

  // Counting frames rather than clocks makes the period follow the refresh rate.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= 8'h00;
    end else if (i_frame) begin
      if (count_q >= period - 8'h01) begin
        count_q <= 8'h00;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // A rate change mid-cycle just wraps early; the glitch lasts one blink at most.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_blink_on <= 1'b1;
    end else begin
      o_blink_on <= (count_q < on_len);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  fast_wrap_a: assert property (i_frame && i_rate == 2'h1 && count_q == 8'h1f
                                |=> count_q == 8'h00)
    else $error("fast blink did not wrap after 32 frames");
  duty_slow_a: assert property (i_rate == 2'h0 && $stable(i_rate) && count_q == 8'h30
                                |=> !o_blink_on)
    else $error("75/25 blink still on after 48 frames");
endmodule

/* rtl/pdc_core.sv */
`timescale 1ns/100ps
`include "pdc_params.svh"
module pdc_core (
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // Host register port.
  input  wire logic                   i_cs_n,
  input  wire logic [1:0]             i_command_select_lines,
  input  wire logic                   i_host_read_not_write,
  input  wire logic [7:0]             i_host_data_byte,
  output logic      [7:0]             o_host_data_byte,
  output logic                        o_host_data_oe,
  // Pixel side.
  input  wire logic                   i_load,
  input  wire logic                   i_frame,
  input  wire pdc_pkg::pdc_pixels_t   i_pixels,
  input  wire pdc_pkg::pdc_overlays_t i_overlays,
  input  wire pdc_pkg::pdc_rgb_t      i_converter_rgb,
  output pdc_pkg::pdc_lookups_t       o_lookups,
  output logic      [4:0]             o_slot_valid
);
  import pdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic       rst_meta_q;
  logic       rst_n;
  logic       blink_on;
  pdc_state_t state_q;
  logic [7:0] address_q;
  logic [7:0] display_control_q;
  logic [7:0] pixel_read_mask_q;
  logic [7:0] pixel_blink_mask_q;
  logic [3:0] converter_readback_q;
  logic       req_rd;
  logic       req_wr;
  logic [7:0] rd_value;

  // Assert at once, release two edges later so all state leaves reset together.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Nibble of the converter data seen through the readback controls.
  function automatic logic [3:0] readback_nibble(input logic [3:0] ctl, input pdc_rgb_t rgb);
    logic [7:0] color;
    color = 8'h00;
    case (ctl[2:0])
      3'b001:  color = rgb.red;
      3'b010:  color = rgb.green;
      3'b100:  color = rgb.blue;
      default: color = 8'h00; // Undefined combinations read as zero.
    endcase
    readback_nibble = ctl[`PDC_RB_LOW_NIBBLE] ? color[3:0] : color[7:4];
  endfunction

  // Build one lookup request from a pixel slot.
  function automatic pdc_lookup_t slot_lookup(input logic [7:0] pix, input logic [1:0] ov,
                                              input logic [7:0] ctl, input logic [7:0] rmask,
                                              input logic [7:0] bmask, input logic on);
    pdc_lookup_t r;
    logic [1:0]  ovm;
    r = '0;
    // Planes enabled for blinking drop to zero during the off phase.
    r.index = pix & rmask & ~(bmask & {8{~on}});
    ovm[1] = ov[1] & ctl[`PDC_CTL_OV1_SHOW] & ~(ctl[`PDC_CTL_OV1_BLINK] & ~on);
    ovm[0] = ov[0] & ctl[`PDC_CTL_OV0_SHOW] & ~(ctl[`PDC_CTL_OV0_BLINK] & ~on);
    r.overlay = ovm;
    r.use_palette = (ovm == 2'h0) & ctl[`PDC_CTL_RAM_EN];
    slot_lookup = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Host access sequencer.

  // One access per chip select low period; the strobe must go high between accesses.
  assign req_wr = (state_q == PDC_IDLE) && !i_cs_n && !i_host_read_not_write;
  assign req_rd = (state_q == PDC_IDLE) && !i_cs_n && i_host_read_not_write;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PDC_IDLE;
    end else begin
      case (state_q)
        PDC_IDLE: begin
          if (req_wr) begin
            state_q <= PDC_WRITE;
          end else if (req_rd) begin
            state_q <= PDC_READ;
          end
        end
        PDC_WRITE, PDC_READ: begin
          if (i_cs_n) begin
            state_q <= PDC_IDLE;
          end
        end
        default: state_q <= PDC_IDLE;
      endcase
    end
  end

  // Value returned for a read, chosen by select lines and address.
  always_comb begin
    rd_value = 8'h00;
    if (i_command_select_lines == `PDC_SEL_ADDRESS) begin
      rd_value = address_q;
    end else if (i_command_select_lines == `PDC_SEL_CONTROL) begin
      case (address_q)
        `PDC_OFS_READ_MASK:  rd_value = pixel_read_mask_q;
        `PDC_OFS_BLINK_MASK: rd_value = pixel_blink_mask_q;
        `PDC_OFS_CONTROL:    rd_value = display_control_q;
        `PDC_OFS_READBACK:   rd_value = {readback_nibble(converter_readback_q, i_converter_rgb),
                                         converter_readback_q};
        default:             rd_value = 8'h00;
      endcase
    end
  end

  // Read data is captured at the request and held while chip select stays low.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_host_data_byte <= 8'h00;
      o_host_data_oe   <= 1'b0;
    end else begin
      if (req_rd) begin
        o_host_data_byte <= rd_value;
      end
      o_host_data_oe <= req_rd || (state_q == PDC_READ && !i_cs_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_q <= 8'h00;
    end else if (req_wr && i_command_select_lines == `PDC_SEL_ADDRESS) begin
      address_q <= i_host_data_byte;
    end
  end

  // Control writes land through the address register like the masks.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      display_control_q    <= `PDC_CONTROL_RESET;
      pixel_read_mask_q    <= `PDC_READ_MASK_RESET;
      pixel_blink_mask_q   <= `PDC_BLINK_MASK_RESET;
      converter_readback_q <= `PDC_READBACK_RESET;
    end else if (req_wr && i_command_select_lines == `PDC_SEL_CONTROL) begin
      case (address_q)
        `PDC_OFS_READ_MASK:  pixel_read_mask_q    <= i_host_data_byte;
        `PDC_OFS_BLINK_MASK: pixel_blink_mask_q   <= i_host_data_byte;
        `PDC_OFS_CONTROL:    display_control_q    <= i_host_data_byte;
        `PDC_OFS_READBACK:   converter_readback_q <= i_host_data_byte[3:0];
        default:             converter_readback_q <= converter_readback_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Blink clock and pixel path.

  pdc_blink u_blink (
    .i_clk      (i_clk),
    .i_rst_n    (rst_n),
    .i_frame    (i_frame),
    .i_rate     (display_control_q[`PDC_CTL_RATE_HI:`PDC_CTL_RATE_LO]),
    .o_blink_on (blink_on)
  );

  // Slot five only carries data in five-to-one mode; the card leaves it grounded.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_slot_valid <= 5'h0f;
    end else begin
      o_slot_valid <= {display_control_q[`PDC_CTL_MUX5], 4'hf};
    end
  end

  // Slots 0 to 3 are masked the same way at the load strobe; slot 4 is zeroed unless in five-to-one mode.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_lookups <= '0;
    end else if (i_load) begin
      for (int s = 0; s < 5; s++) begin
        if (s == 4 && !display_control_q[`PDC_CTL_MUX5]) begin
          o_lookups[s] <= '0;
        end else begin
          o_lookups[s] <= slot_lookup(i_pixels[s], i_overlays[s], display_control_q,
                                      pixel_read_mask_q, pixel_blink_mask_q,
                                      blink_on);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_write;
    req_wr && i_command_select_lines == `PDC_SEL_ADDRESS;
  endsequence

  sequence s_red_high_read;
    req_rd && i_command_select_lines == `PDC_SEL_CONTROL && address_q == `PDC_OFS_READBACK &&
    converter_readback_q == 4'h1;
  endsequence

  addr_load_a: assert property (s_addr_write |=> address_q == $past(i_host_data_byte))
    else $error("address register did not take host byte");
  addr_read_a: assert property (req_rd && i_command_select_lines == `PDC_SEL_ADDRESS
                                |=> o_host_data_oe && o_host_data_byte == $past(address_q))
    else $error("address register not returned on read");
  red_nibble_a: assert property (s_red_high_read
                                 |=> o_host_data_byte[7:4] == $past(i_converter_rgb.red[7:4]))
    else $error("readback did not return red high nibble");
  mux_slot_a: assert property (o_slot_valid[4] == $past(display_control_q[`PDC_CTL_MUX5]))
    else $error("fifth slot validity does not follow multiplex bit");
  ram_enable_a: assert property (i_load && !display_control_q[`PDC_CTL_RAM_EN]
                                 |=> !o_lookups[0].use_palette)
    else $error("palette used while overlay color zero selected");
  ov1_hide_a: assert property (i_load && !display_control_q[`PDC_CTL_OV1_SHOW]
                               |=> !o_lookups[1].overlay[1])
    else $error("overlay high input not forced to zero");
  ov0_hide_a: assert property (i_load && !display_control_q[`PDC_CTL_OV0_SHOW]
                               |=> !o_lookups[2].overlay[0])
    else $error("overlay low input not forced to zero");
  ov1_blink_a: assert property (i_load && display_control_q[`PDC_CTL_OV1_BLINK] && !blink_on
                                |=> !o_lookups[0].overlay[1])
    else $error("overlay high input visible during blink off");
  ov0_blink_a: assert property (i_load && display_control_q[`PDC_CTL_OV0_BLINK] && !blink_on
                                |=> !o_lookups[0].overlay[0])
    else $error("overlay low input visible during blink off");
  read_mask_a: assert property (i_load |=> (o_lookups[3].index & ~$past(pixel_read_mask_q)) == 8'h00)
    else $error("masked pixel plane reached lookup");
  blink_mask_a: assert property (i_load && !blink_on
                                 |=> (o_lookups[0].index & $past(pixel_blink_mask_q)) == 8'h00)
    else $error("blinking plane not cleared in off phase");
endmodule

/* testbench/pdc_video_src.sv */
`timescale 1ns/100ps
// Graphics controller stand-in that sends a requested number of frame strobes.
module pdc_video_src (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_count,
  output logic            o_frame,
  output logic            o_busy
);
  import pdc_pkg::*;
  logic [7:0] left_q = 8'h00;
  logic [1:0] gap_q  = 2'h0;
  initial o_frame = 1'b0;
  //////////////////////////////
  // Strobes come four cycles apart; their spacing plays the refresh rate.
  always @(posedge i_clk) begin
    gap_q   <= gap_q + 2'h1;
    o_frame <= 1'b0;
    if (i_start) begin
      left_q <= i_count;
    end else if (left_q != 8'h00 && gap_q == 2'h3) begin
      left_q  <= left_q - 8'h01;
      o_frame <= 1'b1;
    end
  end
  // Busy lets the bench wait for the last strobe without a fixed delay.
  assign o_busy = (left_q != 8'h00);
endmodule

/* testbench/tb_palette_dac_control_regs.sv */
`timescale 1ns/100ps
`include "pdc_params.svh"
// Drivers note expected results in queues; a monitor checks them in order.
module tb_palette_dac_control_regs;
  import pdc_pkg::*;
  typedef struct packed {
    pdc_lookups_t lk;
    logic [4:0]   sv;
  } pdc_tbexp_t;
  logic          clk;
  logic          rstn  = 1'b0;
  logic          cs_n  = 1'b1;
  logic          rnw   = 1'b0;
  logic          load  = 1'b0;
  logic          start = 1'b0;
  logic [1:0]    sel   = 2'h0;
  logic [7:0]    wdata = 8'h00;
  logic [7:0]    count = 8'h00;
  pdc_pixels_t   pix   = '0;
  pdc_overlays_t ovl   = '0;
  pdc_rgb_t      rgb   = '0;
  logic          busy, frame, oe, ld_q, oe_q;
  logic [7:0]    rdata, ctl, m, b;
  pdc_lookups_t  lk;
  logic [4:0]    sv;
  logic [7:0]    exp_rd[$];
  pdc_tbexp_t    exp_lk[$];
  int            failures = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  logic [1:0]    rt[4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  int            n1[4] = '{20, 40, 40, 40};
  int            n2[4] = '{12, 24, 24, 88};
  logic          on1[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0]    rbc[9] = '{8'h01, 8'h09, 8'h02, 8'h0a, 8'h04, 8'h0c, 8'h03, 8'h07, 8'h0e};

  pdc_core u_pdc_core (.i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_command_select_lines(sel),
    .i_host_read_not_write(rnw), .i_host_data_byte(wdata), .o_host_data_byte(rdata),
    .o_host_data_oe(oe), .i_load(load), .i_frame(frame), .i_pixels(pix), .i_overlays(ovl),
    .i_converter_rgb(rgb), .o_lookups(lk), .o_slot_valid(sv));
  pdc_video_src u_pdc_video_src (.i_clk(clk), .i_start(start), .i_count(count),
    .o_frame(frame), .o_busy(busy));

  //////////////////////////////
  task automatic cmp8(input string name, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic cmp_lk(input pdc_lookups_t e, input pdc_lookups_t g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error lookups expected %h seen %h", e, g);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One host access: request held over the taking edge and the answer edge.
  task automatic acc(input logic [1:0] s, input logic r, input logic [7:0] d);
    @(posedge clk);
    cs_n  <= 1'b0;
    sel   <= s;
    rnw   <= r;
    wdata <= d;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    acc(`PDC_SEL_ADDRESS, 1'b0, a);
    acc(`PDC_SEL_CONTROL, 1'b0, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(`PDC_SEL_ADDRESS, 1'b0, a);
    exp_rd.push_back(e);
    acc(`PDC_SEL_CONTROL, 1'b1, ~e);
  endtask
  // Lookups expected from control, masks and blink phase; slot 4 idles in 4:1.
  function automatic pdc_lookups_t calc(input pdc_pixels_t p, input pdc_overlays_t o,
                                        input logic [7:0] mk, input logic [7:0] bk,
                                        input logic on);
    pdc_lookups_t r;
    for (int s = 0; s < 5; s++) begin
      r[s].overlay     = o[s] & ctl[1:0] & (on ? 2'h3 : ~ctl[3:2]);
      r[s].index       = p[s] & mk & (on ? 8'hff : ~bk);
      r[s].use_palette = (r[s].overlay == 2'h0) & ctl[6];
      if (s == 4 && !ctl[7]) r[s] = '0;
    end
    return r;
  endfunction
  function automatic logic [3:0] nib(input logic [3:0] c);
    logic [7:0] v;
    case (c[2:0])
      3'h1: v = rgb.red;
      3'h2: v = rgb.green;
      3'h4: v = rgb.blue;
      default: return 4'h0;
    endcase
    return c[3] ? v[3:0] : v[7:4];
  endfunction
  // Pixel groups, back to back when n is above one.
  task automatic grp(input int n, input logic [7:0] mk, input logic [7:0] bk, input logic on);
    pdc_tbexp_t    e;
    pdc_pixels_t   p;
    pdc_overlays_t o;
    repeat (n) begin
      p    = 40'({$urandom, $urandom});
      o    = 10'($urandom);
      e.lk = calc(p, o, mk, bk, on);
      e.sv = ctl[7] ? 5'h1f : 5'h0f;
      exp_lk.push_back(e);
      @(posedge clk);
      pix  <= p;
      ovl  <= o;
      load <= 1'b1;
    end
    @(posedge clk);
    load <= 1'b0;
  endtask
  // The task returns only after the model goes idle and the phase registers.
  task automatic frames(input int n);
    @(posedge clk);
    start <= 1'b1;
    count <= 8'(n);
    @(posedge clk);
    start <= 1'b0;
    repeat (2000) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    repeat (4) @(posedge clk);
  endtask

  //////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Monitor compares each result, oldest note first.
  always @(posedge clk) begin : mon
    pdc_tbexp_t e;
    if (ld_q === 1'b1 && exp_lk.size() > 0) begin
      e = exp_lk.pop_front();
      cmp_lk(e.lk, lk);
      cmp8("slot valid", {3'h0, e.sv}, {3'h0, sv});
    end
    if (oe === 1'b1 && oe_q !== 1'b1 && exp_rd.size() > 0) begin
      cmp8("read data", exp_rd.pop_front(), rdata);
    end
    ld_q = load;
    oe_q = oe;
  end
  // A hang counts as a mismatch; the run needs about 2200 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      failures++;
      $display("Error timeout after %0d cycles", cycles);
      end_of_test();
    end
  end
  initial begin
    void'($urandom(22781));
    ctl = `PDC_CONTROL_RESET;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`PDC_OFS_CONTROL, 8'h43);
    rd(`PDC_OFS_READ_MASK, 8'hff);
    rd(`PDC_OFS_BLINK_MASK, 8'h00);
    rd(`PDC_OFS_READBACK, 8'h00);
    rd(8'h02, 8'h00);
    exp_rd.push_back(8'h02);
    acc(`PDC_SEL_ADDRESS, 1'b1, 8'h5a);
    // Random control, masks and pixels in both multiplex ratios, no frames yet.
    for (int k = 0; k < 12; k++) begin
      ctl = {k[0], 7'($urandom)};
      m   = $urandom;
      b   = $urandom;
      wr(`PDC_OFS_CONTROL, ctl);
      wr(`PDC_OFS_READ_MASK, m);
      wr(`PDC_OFS_BLINK_MASK, b);
      rd(`PDC_OFS_CONTROL, ctl);
      rd(`PDC_OFS_BLINK_MASK, b);
      grp(1 + k % 3, m, b, 1'b1);
    end
    // Each blink rate: one phase check mid period, then back to the on phase.
    wr(`PDC_OFS_READ_MASK, 8'hff);
    wr(`PDC_OFS_BLINK_MASK, 8'ha5);
    for (int t = 0; t < 4; t++) begin
      ctl = {2'h1, rt[t], 4'hf};
      wr(`PDC_OFS_CONTROL, ctl);
      frames(n1[t]);
      grp(1, 8'hff, 8'ha5, on1[t]);
      frames(n2[t]);
      grp(1, 8'hff, 8'ha5, 1'b1);
    end
    // Converter readback for every colour, both nibbles and bad enable sets.
    @(posedge clk);
    rgb <= 24'($urandom);
    foreach (rbc[i]) begin
      wr(`PDC_OFS_READBACK, rbc[i]);
      rd(`PDC_OFS_READBACK, {nib(rbc[i][3:0]), rbc[i][3:0]});
    end
    wr(`PDC_OFS_READBACK, 8'h00);
    rd(`PDC_OFS_READBACK, 8'h00);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
